// ==== logic/ira_rate_top.sv ====
// own-address register, bit-rate generator and line timing engine
//
// Notes on behaviour
// - own address lives in register bits seven..one
// - multiplier code gives factor one, two, four
// - rate code selects divider and hold values
// - bit period equals multiplier times divider
// - data changes multiplier times data-hold after a bit or stop command
// - start waits multiplier times start-hold before clock falls
// - stop waits multiplier times stop-hold before data rises
// - codes 00..07 use first table group
// - codes 08..0f use second table group
// - codes 10..17 use third table group
// - codes 18..1f use fourth table group
`timescale 1ns/10ps
module ira_rate_top (
  // clock, reset, enable
  input  wire logic                        ref_clk_i,
  input  wire logic                        rst_i,
  input  wire logic                        ce_i,
  // apb slave
  input  wire logic                        psel_i,
  input  wire logic                        penable_i,
  input  wire logic                        pwrite_i,
  input  wire logic [ira_pkg::PADDR_W-1:0] paddr_i,
  input  wire logic [31:0]                 pwdata_i,
  output logic      [31:0]                 prdata_o,
  output logic                             pready_o,
  output logic                             pslverr_o,
  // serial clock line (open drain)
  input  wire logic                        scl_i,
  output logic                             scl_o,
  output logic                             scl_oe_o,
  // serial data line (open drain)
  input  wire logic                        sda_i,
  output logic                             sda_o,
  output logic                             sda_oe_o,
  // address compare from the protocol engine
  input  wire logic [7:0]                  cmp_byte_i,
  input  wire logic                        cmp_valid_i,
  output logic                             addr_match_o
);

  // ==========================================================
  // declarations
  typedef enum logic [3:0] {
    ST_IDLE,
    ST_START,
    ST_HELD,
    ST_BIT_HOLD,
    ST_BIT_REST,
    ST_BIT_HIGH,
    ST_STOP_HOLD,
    ST_STOP_REST,
    ST_STOP_RISE
  } ira_state_t;

  ira_state_t                state_reg;
  ira_state_t                state_next;
  logic [6:0]                own_bus_address_reg;
  logic [7:0]                bit_rate_divider_reg;
  logic                      enable_reg;
  logic                      bit_val_reg;
  logic                      cmd_start;
  logic                      cmd_stop;
  logic                      cmd_bit;
  logic                      apb_done;
  logic                      apb_write;
  logic [31:0]               rdata_next;
  logic                      rerr_next;
  logic [2:0]                scl_sync_reg;
  logic [2:0]                sda_sync_reg;
  logic                      scl_level_reg;
  logic                      sda_level_reg;
  logic [1:0]                mul_shift;
  ira_pkg::ira_timing_t      timing;
  logic [ira_pkg::CNT_W-1:0] sda_cnt;
  logic [ira_pkg::CNT_W-1:0] rest_cnt;
  logic [ira_pkg::CNT_W-1:0] high_cnt;
  logic [ira_pkg::CNT_W-1:0] start_cnt;
  logic [ira_pkg::CNT_W-1:0] stop_cnt;
  logic                      cnt_load;
  logic [ira_pkg::CNT_W-1:0] cnt_val;
  logic                      cnt_run;
  logic                      cnt_done;
  logic                      scl_pull_next;
  logic                      sda_pull_next;

  // ==========================================================
  // apb handshake
  // a transfer completes at the edge where pready is seen high
  assign apb_done  = psel_i && penable_i && pready_o;
  assign apb_write = apb_done && pwrite_i;

  // one wait cycle in the access phase, then answer
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      pready_o  <= 1'b0;
      prdata_o  <= '0;
      pslverr_o <= 1'b0;
    end else if (ce_i) begin
      if (psel_i && penable_i && !pready_o) begin
        pready_o  <= 1'b1;
        prdata_o  <= pwrite_i ? '0 : rdata_next;
        pslverr_o <= rerr_next;
      end else begin
        pready_o  <= 1'b0;
        prdata_o  <= '0;
        pslverr_o <= 1'b0;
      end
    end
  end

  // read mux; unmapped addresses read zero and flag an error
  always_comb begin
    rdata_next = '0;
    rerr_next  = 1'b0;
    case (paddr_i)
      ira_pkg::ADDR_OWN: begin
        rdata_next[ira_pkg::OWN_HI:ira_pkg::OWN_LO] = own_bus_address_reg;
      end
      ira_pkg::ADDR_DIV: begin
        rdata_next[7:0] = bit_rate_divider_reg;
      end
      ira_pkg::ADDR_CTRL: begin
        rdata_next[ira_pkg::CTRL_EN]  = enable_reg;
        rdata_next[ira_pkg::CTRL_VAL] = bit_val_reg;
      end
      ira_pkg::ADDR_STAT: begin
        rdata_next[ira_pkg::STAT_BUSY]  = (state_reg != ST_IDLE)
                                       && (state_reg != ST_HELD);
        rdata_next[ira_pkg::STAT_SCL]   = scl_level_reg;
        rdata_next[ira_pkg::STAT_SDA]   = sda_level_reg;
        rdata_next[ira_pkg::STAT_MATCH] = addr_match_o;
        rdata_next[ira_pkg::STAT_HELD]  = (state_reg == ST_HELD);
      end
      default: begin
        rerr_next = 1'b1;
      end
    endcase
  end

  // ==========================================================
  // configuration registers
  // own address keeps bits seven..one; bit zero is not stored
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      own_bus_address_reg <= ira_pkg::OWN_RST;
    end else if (ce_i && apb_write && paddr_i == ira_pkg::ADDR_OWN) begin
      own_bus_address_reg <=
        pwdata_i[ira_pkg::OWN_HI:ira_pkg::OWN_LO];
    end
  end

  // multiplier and rate code; takes effect at the next interval
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      bit_rate_divider_reg <= ira_pkg::DIV_RST;
    end else if (ce_i && apb_write && paddr_i == ira_pkg::ADDR_DIV) begin
      bit_rate_divider_reg <= pwdata_i[7:0];
    end
  end

  // enable and the data bit to send
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      enable_reg  <= 1'b0;
      bit_val_reg <= 1'b0;
    end else if (ce_i && apb_write && paddr_i == ira_pkg::ADDR_CTRL) begin
      enable_reg  <= pwdata_i[ira_pkg::CTRL_EN];
      bit_val_reg <= pwdata_i[ira_pkg::CTRL_VAL];
    end
  end

  // command strobes are write-one pulses; ignored unless the engine
  // is in the state that can take them
  assign cmd_start = apb_write && paddr_i == ira_pkg::ADDR_CTRL
                  && pwdata_i[ira_pkg::CTRL_START];
  assign cmd_stop  = apb_write && paddr_i == ira_pkg::ADDR_CTRL
                  && pwdata_i[ira_pkg::CTRL_STOP];
  assign cmd_bit   = apb_write && paddr_i == ira_pkg::ADDR_CTRL
                  && pwdata_i[ira_pkg::CTRL_BIT];

  // ==========================================================
  // own address compare
  // the same seven bits serve the 7-bit address and the low part of
  // a 10-bit address; the engine presents the matching byte
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      addr_match_o <= 1'b0;
    end else if (ce_i && cmp_valid_i) begin
      addr_match_o <= (cmp_byte_i[7:1] == own_bus_address_reg);
    end
  end

  // ==========================================================
  // pin input synchronisers
  // a level is accepted only once stages two and three agree
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      scl_sync_reg  <= 3'h7;
      sda_sync_reg  <= 3'h7;
      scl_level_reg <= 1'b1;
      sda_level_reg <= 1'b1;
    end else if (ce_i) begin
      scl_sync_reg <= {scl_sync_reg[1:0], scl_i};
      sda_sync_reg <= {sda_sync_reg[1:0], sda_i};
      if (scl_sync_reg[1] == scl_sync_reg[2]) begin
        scl_level_reg <= scl_sync_reg[2];
      end
      if (sda_sync_reg[1] == sda_sync_reg[2]) begin
        sda_level_reg <= sda_sync_reg[2];
      end
    end
  end

  // ==========================================================
  // rate lookup and scaled interval lengths
  ira_rate_lut u_lut (
    .rate_code_i (bit_rate_divider_reg[ira_pkg::CODE_HI:ira_pkg::CODE_LO]),
    .timing_o    (timing)
  );

  // reserved multiplier code behaves as factor one
  always_comb begin
    case (bit_rate_divider_reg[ira_pkg::MUL_HI:ira_pkg::MUL_LO])
      ira_pkg::MUL_X1: mul_shift = ira_pkg::SHIFT_X1;
      ira_pkg::MUL_X2: mul_shift = ira_pkg::SHIFT_X2;
      ira_pkg::MUL_X4: mul_shift = ira_pkg::SHIFT_X4;
      default:         mul_shift = ira_pkg::SHIFT_X1;
    endcase
  end

  // every interval is a table-derived value times the multiplier; the low
  // half of a bit is split into data hold and the remainder, so the
  // whole bit lasts multiplier times divider cycles
  assign sda_cnt   = {4'h0, timing.sda_hold} << mul_shift;
  assign rest_cnt  = {4'h0, (timing.divider >> 1) - timing.sda_hold}
                   << mul_shift;
  assign high_cnt  = {4'h0, timing.divider >> 1} << mul_shift;
  assign start_cnt = {4'h0, timing.start_hold} << mul_shift;
  assign stop_cnt  = {4'h0, timing.stop_hold} << mul_shift;

  ira_delay_counter u_cnt (
    .ref_clk_i  (ref_clk_i),
    .rst_i      (rst_i),
    .ce_i       (ce_i),
    .load_i     (cnt_load),
    .load_val_i (cnt_val),
    .run_i      (cnt_run),
    .done_o     (cnt_done)
  );

  // ==========================================================
  // line timing engine
  // the high phase counts only while the clock line reads high, so a
  // slave that stretches the clock lengthens the bit
  always_comb begin
    state_next = state_reg;
    cnt_load   = 1'b0;
    cnt_val    = '0;
    cnt_run    = 1'b1;
    case (state_reg)
      ST_IDLE: begin
        if (cmd_start) begin
          state_next = ST_START;                     // data falls now
          cnt_load   = 1'b1;
          cnt_val    = start_cnt;
        end
      end
      ST_START: begin
        if (cnt_done) begin
          state_next = ST_HELD;                      // clock falls
        end
      end
      ST_HELD: begin
        if (cmd_bit) begin
          state_next = ST_BIT_HOLD;
          cnt_load   = 1'b1;
          cnt_val    = sda_cnt;
        end else if (cmd_stop) begin
          state_next = ST_STOP_HOLD;
          cnt_load   = 1'b1;
          cnt_val    = sda_cnt;
        end
      end
      ST_BIT_HOLD: begin
        if (cnt_done) begin
          state_next = ST_BIT_REST;                  // data changes
          cnt_load   = 1'b1;
          cnt_val    = rest_cnt;
        end
      end
      ST_BIT_REST: begin
        if (cnt_done) begin
          state_next = ST_BIT_HIGH;                  // clock released
          cnt_load   = 1'b1;
          cnt_val    = high_cnt;
        end
      end
      ST_BIT_HIGH: begin
        cnt_run = scl_level_reg;
        if (cnt_done) begin
          state_next = ST_HELD;                      // clock falls
        end
      end
      ST_STOP_HOLD: begin
        if (cnt_done) begin
          state_next = ST_STOP_REST;                 // data pulled low
          cnt_load   = 1'b1;
          cnt_val    = rest_cnt;
        end
      end
      ST_STOP_REST: begin
        if (cnt_done) begin
          state_next = ST_STOP_RISE;                 // clock released
          cnt_load   = 1'b1;
          cnt_val    = stop_cnt;
        end
      end
      ST_STOP_RISE: begin
        cnt_run = scl_level_reg;
        if (cnt_done) begin
          state_next = ST_IDLE;                      // data rises
        end
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase
    // disabling drops any transfer and releases both lines at once
    if (!enable_reg) begin
      state_next = ST_IDLE;
      cnt_load   = 1'b0;
    end
  end

  // state register
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      state_reg <= ST_IDLE;
    end else if (ce_i) begin
      state_reg <= state_next;
    end
  end

  // ==========================================================
  // line drive, derived from the next state so pins move with it
  always_comb begin
    case (state_next)
      ST_IDLE:      scl_pull_next = 1'b0;
      ST_START:     scl_pull_next = 1'b0;
      ST_BIT_HIGH:  scl_pull_next = 1'b0;
      ST_STOP_RISE: scl_pull_next = 1'b0;
      default:      scl_pull_next = 1'b1;
    endcase
  end

  // data is held across the low phase until the hold interval ends
  always_comb begin
    case (state_next)
      ST_IDLE:      sda_pull_next = 1'b0;
      ST_START:     sda_pull_next = 1'b1;
      ST_BIT_REST:  sda_pull_next = !bit_val_reg;
      ST_BIT_HIGH:  sda_pull_next = sda_oe_o;
      ST_STOP_REST: sda_pull_next = 1'b1;
      ST_STOP_RISE: sda_pull_next = 1'b1;
      default:      sda_pull_next = sda_oe_o;
    endcase
  end

  // open-drain outputs: the driven level is always low
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      scl_o    <= 1'b0;
      sda_o    <= 1'b0;
      scl_oe_o <= 1'b0;
      sda_oe_o <= 1'b0;
    end else if (ce_i) begin
      scl_o    <= 1'b0;
      sda_o    <= 1'b0;
      scl_oe_o <= scl_pull_next;
      sda_oe_o <= sda_pull_next;
    end
  end

endmodule

// ==== common/ira_pkg.sv ====
// package: register map, field layout, timing lookup for the rate block
package ira_pkg;

  // ==========================================================
  // register map (byte addresses on the apb bus)
  localparam int          PADDR_W     = 8;
  localparam logic [7:0]  ADDR_OWN    = 8'h00;
  localparam logic [7:0]  ADDR_DIV    = 8'h04;
  localparam logic [7:0]  ADDR_CTRL   = 8'h08;
  localparam logic [7:0]  ADDR_STAT   = 8'h0c;

  // ==========================================================
  // field positions and reset values
  localparam int          OWN_HI      = 7;
  localparam int          OWN_LO      = 1;
  localparam int          MUL_HI      = 7;
  localparam int          MUL_LO      = 6;
  localparam int          CODE_HI     = 5;
  localparam int          CODE_LO     = 0;
  localparam int          CTRL_EN     = 0;
  localparam int          CTRL_START  = 1;
  localparam int          CTRL_STOP   = 2;
  localparam int          CTRL_BIT    = 3;
  localparam int          CTRL_VAL    = 4;
  localparam int          STAT_BUSY   = 0;
  localparam int          STAT_SCL    = 1;
  localparam int          STAT_SDA    = 2;
  localparam int          STAT_MATCH  = 3;
  localparam int          STAT_HELD   = 4;
  localparam logic [6:0]  OWN_RST     = 7'h00;
  localparam logic [7:0]  DIV_RST     = 8'h00;

  // multiplier select codes and their shift amounts
  localparam logic [1:0]  MUL_X1      = 2'h0;
  localparam logic [1:0]  MUL_X2      = 2'h1;
  localparam logic [1:0]  MUL_X4      = 2'h2;
  localparam logic [1:0]  SHIFT_X1    = 2'h0;
  localparam logic [1:0]  SHIFT_X2    = 2'h1;
  localparam logic [1:0]  SHIFT_X4    = 2'h2;

  // ==========================================================
  // timing lookup
  localparam int          CNT_W       = 12;
  localparam logic [4:0]  CODE_MAX    = 5'h1f;

  typedef struct packed {
    logic [7:0] divider;
    logic [7:0] sda_hold;
    logic [7:0] start_hold;
    logic [7:0] stop_hold;
  } ira_timing_t;

  localparam logic [7:0] DIV_TAB [0:31] = '{
    8'h14, 8'h16, 8'h18, 8'h1a, 8'h1c, 8'h1e, 8'h22, 8'h28,
    8'h1c, 8'h20, 8'h24, 8'h28, 8'h2c, 8'h30, 8'h38, 8'h44,
    8'h30, 8'h38, 8'h40, 8'h48, 8'h50, 8'h58, 8'h68, 8'h80,
    8'h50, 8'h60, 8'h70, 8'h80, 8'h90, 8'ha0, 8'hc0, 8'hf0};
  localparam logic [7:0] SDA_TAB [0:31] = '{
    8'h07, 8'h07, 8'h08, 8'h08, 8'h09, 8'h09, 8'h0a, 8'h0a,
    8'h07, 8'h07, 8'h09, 8'h09, 8'h0b, 8'h0b, 8'h0d, 8'h0d,
    8'h09, 8'h09, 8'h0d, 8'h0d, 8'h11, 8'h11, 8'h15, 8'h15,
    8'h09, 8'h09, 8'h11, 8'h11, 8'h19, 8'h19, 8'h21, 8'h21};
  localparam logic [7:0] START_TAB [0:31] = '{
    8'h06, 8'h07, 8'h08, 8'h09, 8'h0a, 8'h0b, 8'h0d, 8'h10,
    8'h0a, 8'h0c, 8'h0e, 8'h10, 8'h12, 8'h14, 8'h18, 8'h1e,
    8'h12, 8'h16, 8'h1a, 8'h1e, 8'h22, 8'h26, 8'h2e, 8'h3a,
    8'h26, 8'h2e, 8'h36, 8'h3e, 8'h46, 8'h4e, 8'h5e, 8'h76};
  // stop hold is start hold plus a per-group offset (groups of eight)
  localparam logic [7:0] STOP_ADD [0:3] = '{
    8'h05, 8'h05, 8'h07, 8'h03};

endpackage

// ==== logic/ira_rate_lut.sv ====
// fixed lookup from rate code to divider and hold values
`timescale 1ns/10ps
module ira_rate_lut (
  // selection
  input  wire logic [5:0]          rate_code_i,
  // looked-up timing
  output ira_pkg::ira_timing_t     timing_o
);

  logic [4:0] idx;

  // codes above the table's top entry saturate to it
  assign idx = rate_code_i[5] ? ira_pkg::CODE_MAX : rate_code_i[4:0];

  // ==========================================================
  // table read
  always_comb begin
    timing_o.divider    = ira_pkg::DIV_TAB[idx];
    timing_o.sda_hold   = ira_pkg::SDA_TAB[idx];
    timing_o.start_hold = ira_pkg::START_TAB[idx];
    timing_o.stop_hold  = ira_pkg::START_TAB[idx]
                        + ira_pkg::STOP_ADD[idx[4:3]];
  end

endmodule

// ==== logic/ira_delay_counter.sv ====
// down counter for bit timing intervals, clocked by the reference clock
`timescale 1ns/10ps
module ira_delay_counter (
  // clock and reset
  input  wire logic                      ref_clk_i,
  input  wire logic                      rst_i,
  input  wire logic                      ce_i,
  // control
  input  wire logic                      load_i,
  input  wire logic [ira_pkg::CNT_W-1:0] load_val_i,
  input  wire logic                      run_i,
  // status
  output logic                           done_o
);

  logic [ira_pkg::CNT_W-1:0] cnt_reg;

  // ==========================================================
  // reload at each interval start, count down while running
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      cnt_reg <= '0;
    end else if (ce_i) begin
      if (load_i) begin
        cnt_reg <= load_val_i;
      end else if (run_i && cnt_reg != '0) begin
        cnt_reg <= cnt_reg - 1'b1;
      end
    end
  end

  // last cycle of an interval of load_val_i cycles
  assign done_o = run_i && (cnt_reg == {{(ira_pkg::CNT_W-1){1'b0}}, 1'b1});

endmodule

// ==== verification/ira_bus_peer.sv ====
// peer device on the two-wire bus: pull-ups and optional clock stretch
`timescale 1ns/10ps
module ira_bus_peer (
  // clock
  input  wire logic       ref_clk_i,
  // line drivers of the block
  input  wire logic       scl_oe_i,
  input  wire logic       sda_oe_i,
  // cycles the peer keeps scl low after each fall, 0 = none
  input  wire logic [3:0] hold_low_i,
  // resolved line levels
  output logic            scl_o,
  output logic            sda_o
);
  logic [3:0] cnt_reg = 4'h0;
  logic       low_reg = 1'b0;
  // a slow peer holds scl low for a while after the block pulls it down
  always_ff @(posedge ref_clk_i) begin
    low_reg <= scl_oe_i;
    if (scl_oe_i && !low_reg) begin
      cnt_reg <= hold_low_i;
    end else if (cnt_reg != 4'h0) begin
      cnt_reg <= cnt_reg - 4'h1;
    end
  end
  // open drain with pull-up: any driver wins low
  assign scl_o = !(scl_oe_i || cnt_reg != 4'h0);
  assign sda_o = !sda_oe_i;
endmodule

// ==== verification/ira_rate_top_asserts.sv ====
// checker: apb answers, register reads, address compare, line timing
`timescale 1ns/10ps
module ira_rate_top_asserts (
  // clock and reset
  input wire logic        ref_clk_i,
  input wire logic        rst_i,
  // apb
  input wire logic        psel_i,
  input wire logic        penable_i,
  input wire logic        pwrite_i,
  input wire logic [7:0]  paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [31:0] prdata_o,
  input wire logic        pready_o,
  input wire logic        pslverr_o,
  // line drivers and compare
  input wire logic        scl_oe_o,
  input wire logic        sda_oe_o,
  input wire logic [7:0]  cmp_byte_i,
  input wire logic        cmp_valid_i,
  input wire logic        addr_match_o
);
  wire        wr = psel_i && penable_i && pready_o && pwrite_i;
  logic [6:0] own_m;
  logic [7:0] div_m;
  logic       st_m;
  int         cc, m, ix, half, hold, sth, sph;
  // shadow of the two rate registers, taken at write completion
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      own_m <= 7'h00;
      div_m <= 8'h00;
    end else if (wr && paddr_i == ira_pkg::ADDR_OWN) begin
      own_m <= pwdata_i[7:1];
    end else if (wr && paddr_i == ira_pkg::ADDR_DIV) begin
      div_m <= pwdata_i[7:0];
    end
  end
  // cycles since the last line command; refused commands would skew it
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      cc <= 0;
      st_m <= 1'b0;
    end else if (wr && paddr_i == ira_pkg::ADDR_CTRL
                 && pwdata_i[3:1] != 3'h0) begin
      cc <= 0;
      st_m <= pwdata_i[1];
    end else begin
      cc <= cc + 1;
    end
  end
  // expected counts; reserved multiplier acts as one, big codes clamp
  always_comb begin
    ix = div_m[5] ? 31 : int'(div_m[4:0]);
    m = div_m[7:6] == ira_pkg::MUL_X2 ? 2 :
        div_m[7:6] == ira_pkg::MUL_X4 ? 4 : 1;
    half = m * ira_pkg::DIV_TAB[ix] / 2;
    hold = m * ira_pkg::SDA_TAB[ix];
    sth = m * ira_pkg::START_TAB[ix];
    sph = half + m * (ira_pkg::START_TAB[ix] + ira_pkg::STOP_ADD[ix / 8]);
  end
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);
  a_apb_wait: assert property (psel_i && !penable_i |=>
    !pready_o ##[1:2] pready_o) else $error("apb answer late");
  a_bad_addr: assert property (pready_o && paddr_i > ira_pkg::ADDR_STAT
    |-> pslverr_o && prdata_o == 32'h0) else $error("unmapped not refused");
  a_own_read: assert property (pready_o && !pwrite_i && !pslverr_o
    && paddr_i == ira_pkg::ADDR_OWN |-> prdata_o == {24'h0, own_m, 1'b0})
    else $error("own address read wrong");
  a_div_read: assert property (pready_o && !pwrite_i
    && paddr_i == ira_pkg::ADDR_DIV |-> prdata_o == {24'h0, div_m})
    else $error("divider read wrong");
  a_match_next: assert property (cmp_valid_i |=>
    addr_match_o == ($past(cmp_byte_i[7:1]) == own_m))
    else $error("address compare wrong");
  a_start_hold: assert property ($rose(scl_oe_o) && st_m
    |-> cc == sth) else $error("start hold wrong");
  a_data_hold: assert property (scl_oe_o && $changed(sda_oe_o)
    |-> cc == hold) else $error("data hold wrong");
  a_low_half: assert property ($fell(scl_oe_o) |-> cc == half)
    else $error("clock low time wrong");
  a_stop_hold: assert property ($fell(sda_oe_o) && !scl_oe_o
    |-> cc >= sph && cc <= sph + 24) else $error("stop hold wrong");
  c_start: cover property ($rose(scl_oe_o) && st_m);
  c_stop: cover property ($fell(sda_oe_o) && !scl_oe_o);
  c_refused: cover property (pready_o && pslverr_o);
endmodule
bind ira_rate_top ira_rate_top_asserts chk_u (.ref_clk_i, .rst_i,
  .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i, .prdata_o,
  .pready_o, .pslverr_o, .scl_oe_o, .sda_oe_o, .cmp_byte_i,
  .cmp_valid_i, .addr_match_o);

// ==== verification/tb.sv ====
// testbench: registers, address compare and line timing of the rate block
`timescale 1ns/10ps
module tb;
  logic        ref_clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        psel_i = 1'b0;
  logic        penable_i = 1'b0;
  logic        pwrite_i = 1'b0;
  logic [7:0]  paddr_i = 8'h00;
  logic [31:0] pwdata_i = 32'h0;
  logic [31:0] prdata_o, rdata, d;
  logic        pready_o, pslverr_o, err, scl, sda, scl_oe_o, sda_oe_o;
  logic [7:0]  cmp_byte_i = 8'h00;
  logic        cmp_valid_i = 1'b0;
  logic        addr_match_o, scl_lo, sda_lo;
  logic [3:0]  hold_low = 4'h0;
  logic [7:0]  cases [7] = '{8'h00, 8'h47, 8'h8f, 8'h17, 8'h5f, 8'h3f,
                             8'hd8};
  int          n_errors = 0, checks = 0, seed = 32'h8dfd, cyc = 0;
  int          n, m, ix, lo;
  ira_rate_top dut_u (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .ce_i(1'b1),
    .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i),
    .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
    .pready_o(pready_o), .pslverr_o(pslverr_o), .scl_i(scl), .scl_o(scl_lo),
    .scl_oe_o(scl_oe_o), .sda_i(sda), .sda_o(sda_lo), .sda_oe_o(sda_oe_o),
    .cmp_byte_i(cmp_byte_i), .cmp_valid_i(cmp_valid_i),
    .addr_match_o(addr_match_o));
  ira_bus_peer peer_u (.ref_clk_i(ref_clk_i), .scl_oe_i(scl_oe_o),
    .sda_oe_i(sda_oe_o), .hold_low_i(hold_low), .scl_o(scl), .sda_o(sda));
  // ==========================================================
  // clock and hang guard
  initial begin
    forever #25 ref_clk_i = ~ref_clk_i;
  end
  always @(posedge ref_clk_i) begin
    cyc++;
    if (cyc == 60000) begin
      n_errors++;
      results();
    end
  end
  // ==========================================================
  // tasks
  task automatic chk(input string nm, input logic [31:0] e, g);
    checks++;
    if (g !== e) begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask
  // one apb transfer; request held until pready is sampled high
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] dt);
    @(posedge ref_clk_i);
    psel_i <= 1'b1;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= dt;
    @(posedge ref_clk_i);
    penable_i <= 1'b1;
    do @(posedge ref_clk_i); while (pready_o !== 1'b1);
    rdata = prdata_o;
    err = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
  endtask
  // count edges until a line driver reaches a level, read just after edge
  task automatic wait_pin(input bit on_scl, input logic v);
    do begin
      @(posedge ref_clk_i);
      #1;
      n++;
    end while (((on_scl ? scl_oe_o : sda_oe_o) !== v) && n < 4000);
  endtask
  task automatic cmp(input logic [7:0] b, input logic e);
    @(posedge ref_clk_i);
    cmp_byte_i <= b;
    cmp_valid_i <= 1'b1;
    @(posedge ref_clk_i);
    cmp_valid_i <= 1'b0;
    @(posedge ref_clk_i);
    #1;
    chk("addr_match", {31'h0, e}, {31'h0, addr_match_o});
  endtask
  // start, one bit, stop at one divider setting
  task automatic line_run(input logic [7:0] dv, input logic b);
    m = dv[7:6] == 2'h1 ? 2 : dv[7:6] == 2'h2 ? 4 : 1;
    ix = dv[5] ? 31 : int'(dv[4:0]);
    lo = m * (ira_pkg::DIV_TAB[ix] / 2 + ira_pkg::START_TAB[ix]
         + (ix < 16 ? 5 : ix < 24 ? 7 : 3));
    d = $random(seed);
    hold_low <= d[3:0];
    apb(1'b1, ira_pkg::ADDR_DIV, {24'h0, dv});
    apb(1'b1, ira_pkg::ADDR_CTRL, 32'h3);
    n = 0;
    wait_pin(1, 1'b1);
    chk("start_hold", m * ira_pkg::START_TAB[ix], n);
    apb(1'b1, ira_pkg::ADDR_CTRL, {27'h0, b, 4'h9});
    n = 0;
    if (b) begin
      wait_pin(0, 1'b0);
      chk("data_hold", m * ira_pkg::SDA_TAB[ix], n);
    end
    wait_pin(1, 1'b0);
    chk("low_time", m * ira_pkg::DIV_TAB[ix] / 2, n);
    n = 0;
    wait_pin(1, 1'b1);
    chk("bit_level", {31'h0, !b}, {31'h0, sda_oe_o});
    chk("pin_low", 32'h0, {30'h0, scl_lo, sda_lo});
    apb(1'b1, ira_pkg::ADDR_CTRL, 32'h5);
    n = 0;
    // a released data line is first pulled low again before it rises
    if (b) begin
      wait_pin(0, 1'b1);
    end
    wait_pin(0, 1'b0);
    chk("stop_hold", 32'h1, {31'h0, n >= lo && n <= lo + 24});
    apb(1'b0, ira_pkg::ADDR_STAT, 32'h0);
    chk("idle", 32'h0, {31'h0, rdata[0]});
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  // ==========================================================
  // main sequence
  initial begin
    repeat (16) @(posedge ref_clk_i);
    rst_i <= 1'b0;
    apb(1'b0, ira_pkg::ADDR_OWN, 32'h0);
    chk("own_reset", 32'h0, rdata);
    apb(1'b0, ira_pkg::ADDR_DIV, 32'h0);
    chk("div_reset", 32'h0, rdata);
    for (int i = 0; i < 4; i++) begin
      d = $random(seed);
      apb(1'b1, ira_pkg::ADDR_OWN, d);
      apb(1'b0, ira_pkg::ADDR_OWN, 32'h0);
      chk("own_rw", {24'h0, d[7:1], 1'b0}, rdata);
      apb(1'b1, ira_pkg::ADDR_DIV, d);
      apb(1'b0, ira_pkg::ADDR_DIV, 32'h0);
      chk("div_rw", {24'h0, d[7:0]}, rdata);
    end
    apb(1'b0, 8'h10, 32'h0);
    chk("unmapped_err", 32'h1, {31'h0, err});
    chk("unmapped_data", 32'h0, rdata);
    $display("test registers done");
    cmp({d[7:1], 1'b1}, 1'b1);
    cmp({~d[7], d[6:1], 1'b0}, 1'b0);
    $display("test compare done");
    // set the enable bit only; this write requests no start
    apb(1'b1, ira_pkg::ADDR_CTRL, 32'h1);
    foreach (cases[i]) line_run(cases[i], i[0]);
    for (int i = 0; i < 3; i++) begin
      d = $random(seed);
      line_run(d[7:0], d[8]);
    end
    $display("test line timing done");
    results();
  end
endmodule
